// file: verilog/rbwx_pkg.sv
package rbwx_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int NARROW_W = 12;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
   localparam logic [APB_AW-1:0] STATUS_OFS = 8'h04;
   localparam logic [APB_AW-1:0] WIDE_OFS = 8'h08;
   localparam logic [APB_AW-1:0] NARROW_OFS = 8'h0C;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_HIZ_NARROW_BIT = 0;
   localparam int CTRL_HIZ_WIDE_BIT = 1;
   localparam int CTRL_W = 2;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
   localparam int STAT_NARROW_DRV_BIT = 0;
   localparam int STAT_WIDE_DRV_BIT = 1;
   localparam int STAT_SEL_BIT = 2;
   localparam int WIDE_SECOND_LSB = 12;
endpackage

// file: verilog/rbwx_en_reg.sv
`timescale 1ns/1ns
// storage register with active-low load enable and no reset
module rbwx_en_reg #(
   parameter int WIDTH = 12
) (
   input wire logic clk_in,
   input wire logic load_n_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   always_ff @(posedge clk_in) begin
      if (!load_n_in) begin
         q_out <= d_in;
      end
   end
endmodule

// file: verilog/rbwx_exchanger.sv
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
// Behaviour
// - registers load on rising edge when enable low
// - sampled select picks first or second half
// - narrow to first half: two stages
// - narrow to second half: one register
// - output enables pass through registers
// - drive enables active low, independent per port
// - both enables high: wide halves hold
// - first half needs two enabled edges
// - second half own enable; first needs both
// - drive state unknown before first edge
module rbwx_exchanger
   import rbwx_pkg::*;
#(
   parameter int WIDTH = rbwx_pkg::NARROW_W
) (
   input wire logic clk_in,
   input wire logic srst_in,
   // narrow port
   input wire logic [WIDTH-1:0] narrow_in,
   output logic [WIDTH-1:0] narrow_out,
   output logic narrow_oe_out,
   // wide port, two halves
   input wire logic [WIDTH-1:0] wide_first_half_in,
   input wire logic [WIDTH-1:0] wide_second_half_in,
   output logic [WIDTH-1:0] wide_first_half_out,
   output logic [WIDTH-1:0] wide_second_half_out,
   output logic wide_oe_out,
   // controls
   input wire logic narrow_to_first_half_enable_n_in,
   input wire logic narrow_to_second_half_enable_n_in,
   input wire logic first_half_to_narrow_enable_n_in,
   input wire logic second_half_to_narrow_enable_n_in,
   input wire logic half_select_in,
   input wire logic narrow_port_drive_n_in,
   input wire logic wide_port_drive_n_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [rbwx_pkg::APB_AW-1:0] paddr_in,
   input wire logic [rbwx_pkg::APB_DW-1:0] pwdata_in,
   output logic [rbwx_pkg::APB_DW-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out
);
   import rbwx_pkg::*;

   // ----------------------------------------------------------------
   // narrow to wide datapath
   // ----------------------------------------------------------------
   logic pipe_load_n;
   logic [WIDTH-1:0] pipe_stage1;

   // the first-half pipe advances only while both enables are low
   assign pipe_load_n = narrow_to_first_half_enable_n_in |
                        narrow_to_second_half_enable_n_in;

   rbwx_en_reg #(
      .WIDTH(WIDTH)
   ) u_first_stage1 (
      .clk_in(clk_in),
      .load_n_in(pipe_load_n),
      .d_in(narrow_in),
      .q_out(pipe_stage1)
   );

   rbwx_en_reg #(
      .WIDTH(WIDTH)
   ) u_first_stage2 (
      .clk_in(clk_in),
      .load_n_in(pipe_load_n),
      .d_in(pipe_stage1),
      .q_out(wide_first_half_out)
   );

   rbwx_en_reg #(
      .WIDTH(WIDTH)
   ) u_second_half (
      .clk_in(clk_in),
      .load_n_in(narrow_to_second_half_enable_n_in),
      .d_in(narrow_in),
      .q_out(wide_second_half_out)
   );

   // ----------------------------------------------------------------
   // wide to narrow datapath
   // ----------------------------------------------------------------
   logic sel_reg;

   // a single register shared by both paths keeps the output straight off a flop;
   // with the chosen half disabled the narrow value simply holds
   always_ff @(posedge clk_in) begin
      if (half_select_in && !first_half_to_narrow_enable_n_in) begin
         narrow_out <= wide_first_half_in;
      end else if (!half_select_in &&
                   !second_half_to_narrow_enable_n_in) begin
         narrow_out <= wide_second_half_in;
      end
   end

   always_ff @(posedge clk_in) begin
      sel_reg <= half_select_in;
   end

   // ----------------------------------------------------------------
   // registered drive enables
   // ----------------------------------------------------------------
   logic [CTRL_W-1:0] ctrl_reg;

   // no reset here on purpose: like the pins, drive state is only
   // known after the first edge, so keep the enables inactive early
   always_ff @(posedge clk_in) begin
      narrow_oe_out <= !narrow_port_drive_n_in &&
                       !ctrl_reg[CTRL_HIZ_NARROW_BIT];
   end

   always_ff @(posedge clk_in) begin
      wide_oe_out <= !wide_port_drive_n_in &&
                     !ctrl_reg[CTRL_HIZ_WIDE_BIT];
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   logic access;
   logic mapped;
   logic [APB_DW-1:0] rd_mux;

   // one wait state: pready rises the cycle after access begins
   assign access = psel_in && penable_in && !pready_out;

   always_comb begin
      mapped = 1'h1;
      rd_mux = '0;
      case (paddr_in)
         CTRL_OFS: begin
            rd_mux[CTRL_W-1:0] = ctrl_reg;
         end
         STATUS_OFS: begin
            rd_mux[STAT_NARROW_DRV_BIT] = narrow_oe_out;
            rd_mux[STAT_WIDE_DRV_BIT] = wide_oe_out;
            rd_mux[STAT_SEL_BIT] = sel_reg;
         end
         WIDE_OFS: begin
            rd_mux[WIDTH-1:0] = wide_first_half_out;
            rd_mux[WIDE_SECOND_LSB +: WIDTH] = wide_second_half_out;
         end
         NARROW_OFS: begin
            rd_mux[WIDTH-1:0] = narrow_out;
         end
         default: begin
            mapped = 1'h0;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pready_out <= 1'h0;
         pslverr_out <= 1'h0;
         prdata_out <= '0;
      end else begin
         pready_out <= access;
         pslverr_out <= access && !mapped;
         if (access && !pwrite_in) begin
            prdata_out <= rd_mux;
         end
      end
   end

   // only the control word is writable; other writes are dropped
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ctrl_reg <= CTRL_RST;
      end else if (psel_in && penable_in && pready_out && pwrite_in &&
                   paddr_in == CTRL_OFS) begin
         ctrl_reg <= pwdata_in[CTRL_W-1:0];
      end
   end
endmodule

// file: dv/rbwx_sva.sv
`timescale 1ns/1ns
module rbwx_sva
   import rbwx_pkg::*;
(
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic narrow_to_first_half_enable_n_in,
   input wire logic narrow_to_second_half_enable_n_in,
   input wire logic narrow_port_drive_n_in,
   input wire logic wide_port_drive_n_in,
   input wire logic narrow_oe_out,
   input wire logic wide_oe_out,
   input wire logic [NARROW_W-1:0] narrow_in,
   input wire logic [NARROW_W-1:0] wide_first_half_out,
   input wire logic [NARROW_W-1:0] wide_second_half_out
);
   wire e1 = narrow_to_first_half_enable_n_in;
   wire e2 = narrow_to_second_half_enable_n_in;
   wire [NARROW_W-1:0] f = wide_first_half_out;
   wire [NARROW_W-1:0] s = wide_second_half_out;
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   sequence adv2;
      !e1 && !e2 ##1 !e1 && !e2;
   endsequence
   a_second_load: assert property (!e2 |=> s == $past(narrow_in))
      else $error("second half load lost");
   a_second_keep: assert property (e2 |=> $stable(s))
      else $error("second half moved");
   a_first_pipe: assert property (
      adv2 |=> f == $past(narrow_in, 2))
      else $error("first half not two stages");
   a_pair_word: assert property (adv2 |=> {s, f} ==
      {$past(narrow_in), $past(narrow_in, 2)}) else $error("pair broken");
   a_first_keep: assert property (e1 || e2 |=> $stable(f))
      else $error("first half moved");
   a_both_idle: assert property ((e1 && e2) [*2] |=>
      {f, s} == $past({f, s}, 2)) else $error("halves moved while idle");
   a_narrow_off: assert property (
      narrow_port_drive_n_in |=> !narrow_oe_out) else $error("narrow on");
   a_wide_off: assert property (
      wide_port_drive_n_in |=> !wide_oe_out) else $error("wide on");
endmodule
bind rbwx_exchanger rbwx_sva u_sva (
   .clk_in(clk_in),
   .srst_in(srst_in),
   .narrow_to_first_half_enable_n_in(narrow_to_first_half_enable_n_in),
   .narrow_to_second_half_enable_n_in(narrow_to_second_half_enable_n_in),
   .narrow_port_drive_n_in(narrow_port_drive_n_in),
   .wide_port_drive_n_in(wide_port_drive_n_in),
   .narrow_oe_out(narrow_oe_out),
   .wide_oe_out(wide_oe_out),
   .narrow_in(narrow_in),
   .wide_first_half_out(wide_first_half_out),
   .wide_second_half_out(wide_second_half_out)
);

// file: dv/rbwx_wide_peer.sv
`timescale 1ns/1ns
// released halves toggle so stale data never looks valid
module rbwx_wide_peer (
   input wire logic clk_in,
   input wire logic dut_drives_in,
   input wire logic [11:0] w1_in,
   input wire logic [11:0] w2_in,
   output logic [11:0] b1_out,
   output logic [11:0] b2_out
);
   always_ff @(posedge clk_in) begin
      b1_out <= dut_drives_in ? ~b1_out : w1_in;
      b2_out <= dut_drives_in ? ~b2_out : w2_in;
   end
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
   import rbwx_pkg::*;
   logic clk, srst_in, e1, e2, b1, b2, sel, dn, dw, noe, woe, pe;
   logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic [11:0] ni, w1, w2, no, f, s, p1, p2;
   logic [7:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, r;
   int num_errors = 0;
   int compares = 0;
   int i;
   rbwx_exchanger dut (.*, .clk_in(clk), .narrow_in(ni), .narrow_out(no),
      .narrow_oe_out(noe), .wide_oe_out(woe), .half_select_in(sel),
      .wide_first_half_in(p1), .wide_second_half_in(p2),
      .wide_first_half_out(f), .wide_second_half_out(s),
      .narrow_to_first_half_enable_n_in(e1),
      .narrow_to_second_half_enable_n_in(e2),
      .first_half_to_narrow_enable_n_in(b1),
      .second_half_to_narrow_enable_n_in(b2),
      .narrow_port_drive_n_in(dn), .wide_port_drive_n_in(dw));
   rbwx_wide_peer peer (.clk_in(clk), .dut_drives_in(woe), .w1_in(w1),
      .w2_in(w2), .b1_out(p1), .b2_out(p2));
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   task finish_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'h2, w, a, d};
      @(posedge clk);
      penable_in <= 1'h1;
      for (i = 0; i < 20 && pready_out !== 1'h1; i++) @(posedge clk);
      {r, pe} = {prdata_out, pslverr_out};
      {psel_in, penable_in} <= 2'h0;
      if (i == 20) begin
         num_errors++;
         finish_test;
      end
   endtask
   task t_pair;
      @(posedge clk);
      {ni, e1, e2} <= {12'hA51, 2'h0};
      @(posedge clk);
      ni <= 12'h3C7;
      @(posedge clk);
      {ni, e1, e2} <= {12'hFFF, 2'h3};
      repeat (3) @(posedge clk);
      {ni, e2} <= {12'h0E2, 1'h0};
      @(posedge clk);
      e2 <= 1'h1;
      @(negedge clk);
      `CHK({s, f}, 24'h0E2A51)
      apb(1'h0, WIDE_OFS, 32'h0);
      `CHK(r, 32'h000E2A51)
   endtask
   task t_btoa;
      @(posedge clk);
      {w1, w2, sel, b1, b2} <= {24'h5B4C3D, 3'h5};
      repeat (2) @(posedge clk);
      {sel, b1, b2} <= 3'h2;
      @(negedge clk);
      `CHK(no, 12'h5B4)
      @(posedge clk);
      sel <= 1'h1;
      @(negedge clk);
      `CHK(no, 12'hC3D)
      apb(1'h0, NARROW_OFS, 32'h0);
      `CHK(r, 32'h00000C3D)
   endtask
   task t_oe;
      @(posedge clk);
      {dn, dw} <= 2'h1;
      @(negedge clk);
      `CHK({noe, woe}, 2'h0)
      @(posedge clk);
      {dn, dw} <= 2'h2;
      @(negedge clk);
      `CHK({noe, woe}, 2'h2)
      @(posedge clk);
      dn <= 1'h0;
      @(negedge clk);
      `CHK({noe, woe}, 2'h1)
      apb(1'h1, CTRL_OFS, 32'h1);
      apb(1'h0, 8'h40, 32'h0);
      `CHK({noe, woe, pe}, 3'h3)
      apb(1'h0, CTRL_OFS, 32'h0);
      `CHK(r, 32'h1)
      // swap the forced high impedance over to the wide side
      apb(1'h1, CTRL_OFS, 32'h2);
      apb(1'h0, STATUS_OFS, 32'h0);
      `CHK(r, 32'h00000005)
      `CHK({noe, woe}, 2'h2)
   endtask
   initial begin
      // controls are defined from time zero with drive requests held
      // inactive; the wide halves are flushed to zero while reset runs
      // so that no check ever meets a register that was never loaded
      {srst_in, e1, e2, b1, b2, dn, dw} = 7'h4F;
      {sel, psel_in, penable_in, pwrite_in, ni, w1, w2} = '0;
      {paddr_in, pwdata_in} = '0;
      repeat (10) @(posedge clk);
      srst_in <= 1'h0;
      {e1, e2} <= 2'h3;
      t_pair;
      t_btoa;
      t_oe;
      finish_test;
   end
endmodule
